//--- rtl/otp_fuse_pkg.sv
package otp_fuse_pkg;

  // Array geometry.
  localparam int FUSE_BITS = 768;
  localparam int BANK_COUNT = 6;
  localparam int BANK_BITS = 128;
  localparam int FIXED_BITS = 108;
  localparam int SW_BITS = 20;
  localparam int WORD_BITS = 32;
  localparam int FUSE_WORDS = FUSE_BITS / WORD_BITS;
  localparam int WORDS_PER_BANK = BANK_BITS / WORD_BITS;
  localparam logic [4:0] LAST_WORD = 5'h17;
  localparam logic [2:0] FACTORY_BANK = 3'h3;

  // Field widths.
  localparam int HW_ADDR_W = 48;
  localparam int ADC_W = 8;
  localparam int XO_W = 15;
  localparam int IQ_W = 11;

  // Default bit positions inside one bank.
  localparam int POS_BANK_VALID = 0;
  localparam int POS_BANK_REVOKED = 1;
  localparam int POS_HW_VALID = 2;
  localparam int POS_HW_ADDR = 3;
  localparam int POS_ADC_VALID = 51;
  localparam int POS_ADC = 52;
  localparam int POS_XO_VALID = 60;
  localparam int POS_XO = 61;
  localparam int POS_GAIN_VALID = 76;
  localparam int POS_GAIN = 77;
  localparam int POS_PHASE_VALID = 88;
  localparam int POS_PHASE = 89;

  // Register byte offsets.
  localparam int AXI_AW = 12;
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_FIELD_VALID = 12'h008;
  localparam logic [11:0] OFS_HW_LO = 12'h00c;
  localparam logic [11:0] OFS_HW_HI = 12'h010;
  localparam logic [11:0] OFS_BT_LO = 12'h014;
  localparam logic [11:0] OFS_BT_HI = 12'h018;
  localparam logic [11:0] OFS_XO = 12'h01c;
  localparam logic [11:0] OFS_ADC = 12'h020;
  localparam logic [11:0] OFS_IQ = 12'h024;
  localparam logic [11:0] OFS_SW = 12'h028;
  localparam logic [11:0] OFS_RAW_BASE = 12'h100;
  localparam logic [11:0] OFS_RAW_LAST = 12'h15c;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SEQ_REQ = 3'b001,
    SEQ_CAP = 3'b010,
    SEQ_DONE = 3'b100
  } seq_t;

  typedef struct packed {
    logic hw_addr_valid;
    logic [HW_ADDR_W-1:0] hw_addr;
    logic [HW_ADDR_W-1:0] bt_addr;
    logic adc_valid;
    logic [ADC_W-1:0] adc_trim;
    logic xo_valid;
    logic [XO_W-1:0] xo_trim;
    logic gain_valid;
    logic [IQ_W-1:0] gain_imbalance_trim;
    logic phase_valid;
    logic [IQ_W-1:0] phase_imbalance_trim;
  } calib_t;

endpackage : otp_fuse_pkg

//--- rtl/bank_selector.sv
`timescale 1ns/1ps
module bank_selector
  import otp_fuse_pkg::*;
#(
  parameter int NB = BANK_COUNT
) (
  // Per-bank qualification.
  input wire logic [NB-1:0] bank_ok,
  // Choice.
  output logic found,
  output logic [2:0] index
);

  // Later banks supersede earlier ones, so the highest qualifying bank wins.
  always_comb begin
    found = 1'b0;
    index = 3'h0;
    for (int b = 0; b < NB; b++) begin
      if (bank_ok[b]) begin
        found = 1'b1;
        index = 3'(b);
      end
    end
  end

endmodule : bank_selector

//--- rtl/otp_fuse_bank_reader.sv
// Function
// - All 768 fuse bits are loaded after reset and readable by the processor.
// - Array holds six banks of 128 bits with one common layout.
// - Lowest 108 bank bits are fixed fields; top 20 are software bits.
// - Every value field has its own valid flag.
// - Valid flag 0 means field unusable; 1 means usable.
// - Each bank is qualified independently so later banks can supersede.
// - Bank 3 holds the factory address, crystal and imbalance trims.
// - Second radio address equals stored hardware address plus one.
// - Normal mode applies gain and phase trims only when their flags are 1.
// - Legacy mode ignores gain/phase flags and never applies those trims.
`timescale 1ns/1ps
module otp_fuse_bank_reader
  import otp_fuse_pkg::*;
#(
  parameter int P_BANK_VALID = POS_BANK_VALID,
  parameter int P_BANK_REVOKED = POS_BANK_REVOKED,
  parameter int P_HW_VALID = POS_HW_VALID,
  parameter int P_HW_ADDR = POS_HW_ADDR,
  parameter int P_ADC_VALID = POS_ADC_VALID,
  parameter int P_ADC = POS_ADC,
  parameter int P_XO_VALID = POS_XO_VALID,
  parameter int P_XO = POS_XO,
  parameter int P_GAIN_VALID = POS_GAIN_VALID,
  parameter int P_GAIN = POS_GAIN,
  parameter int P_PHASE_VALID = POS_PHASE_VALID,
  parameter int P_PHASE = POS_PHASE
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave.
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Fuse array read port, data one cycle after the strobe.
  output logic fuse_rd_en,
  output logic [4:0] fuse_rd_addr,
  input wire logic [31:0] fuse_rd_data,
  // Calibration to the radio.
  output calib_t calib,
  output logic calib_ready
);

  typedef struct packed {
    seq_t seq;
    logic [4:0] addr;
    logic [FUSE_WORDS-1:0][WORD_BITS-1:0] words;
    logic legacy;
    logic aw_got;
    logic [AXI_AW-1:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    calib_t calib;
  } state_t;

  localparam state_t ST_RESET = '{seq: SEQ_REQ, default: '0};

  state_t st_r;
  state_t st_nxt;

  function automatic logic [BANK_BITS-1:0] bank_of(input logic [FUSE_WORDS-1:0][WORD_BITS-1:0] w,
                                                   input logic [2:0] b);
    bank_of = w[{b, 2'b00} +: WORDS_PER_BANK];
  endfunction : bank_of

  // Bank qualification and choice.
  logic [BANK_COUNT-1:0] bank_ok;
  logic found;
  logic [2:0] active;
  logic [BANK_BITS-1:0] sel;
  logic done;

  always_comb begin
    logic [BANK_BITS-1:0] bk;
    bk = '0;
    for (int b = 0; b < BANK_COUNT; b++) begin
      bk = bank_of(st_r.words, 3'(b));
      bank_ok[b] = bk[P_BANK_VALID] & ~bk[P_BANK_REVOKED];
    end
  end

  bank_selector #(
    .NB(BANK_COUNT)
  ) u_sel (
    .bank_ok(bank_ok),
    .found(found),
    .index(active)
  );

  assign done = (st_r.seq == SEQ_DONE);
  assign sel = bank_of(st_r.words, active);

  // Decoded field view of the active bank.
  logic hw_ok;
  logic adc_ok;
  logic xo_ok;
  logic gain_ok;
  logic phase_ok;

  assign hw_ok = found & sel[P_HW_VALID];
  assign adc_ok = found & sel[P_ADC_VALID];
  assign xo_ok = found & sel[P_XO_VALID];
  // Legacy mode never consults the imbalance flags, so the trims stay unapplied.
  assign gain_ok = found & ~st_r.legacy & sel[P_GAIN_VALID];
  assign phase_ok = found & ~st_r.legacy & sel[P_PHASE_VALID];

  logic [HW_ADDR_W-1:0] hw_field;
  assign hw_field = sel[P_HW_ADDR +: HW_ADDR_W];

  logic [31:0] rd_mux;
  logic rd_hit;
  logic [AXI_AW-1:0] rd_idx;

  always_comb begin
    rd_mux = 32'h0;
    rd_hit = 1'b1;
    rd_idx = s_axi_araddr - OFS_RAW_BASE;
    if (s_axi_araddr == OFS_CTRL) begin
      rd_mux = {31'h0, st_r.legacy};
    end else if (s_axi_araddr == OFS_STATUS) begin
      rd_mux = {23'h0, found & (active == FACTORY_BANK), 1'b0, active, 2'b00, found, done};
    end else if (s_axi_araddr == OFS_FIELD_VALID) begin
      rd_mux = {27'h0, st_r.calib.phase_valid, st_r.calib.gain_valid, st_r.calib.xo_valid,
                st_r.calib.adc_valid, st_r.calib.hw_addr_valid};
    end else if (s_axi_araddr == OFS_HW_LO) begin
      rd_mux = st_r.calib.hw_addr[31:0];
    end else if (s_axi_araddr == OFS_HW_HI) begin
      rd_mux = {16'h0, st_r.calib.hw_addr[47:32]};
    end else if (s_axi_araddr == OFS_BT_LO) begin
      rd_mux = st_r.calib.bt_addr[31:0];
    end else if (s_axi_araddr == OFS_BT_HI) begin
      rd_mux = {16'h0, st_r.calib.bt_addr[47:32]};
    end else if (s_axi_araddr == OFS_XO) begin
      rd_mux = {17'h0, st_r.calib.xo_trim};
    end else if (s_axi_araddr == OFS_ADC) begin
      rd_mux = {24'h0, st_r.calib.adc_trim};
    end else if (s_axi_araddr == OFS_IQ) begin
      rd_mux = {5'h0, st_r.calib.phase_imbalance_trim, 5'h0, st_r.calib.gain_imbalance_trim};
    end else if (s_axi_araddr == OFS_SW) begin
      rd_mux = {12'h0, sel[BANK_BITS-1:FIXED_BITS]};
    end else if (s_axi_araddr >= OFS_RAW_BASE && s_axi_araddr <= OFS_RAW_LAST &&
                 s_axi_araddr[1:0] == 2'b00) begin
      rd_mux = st_r.words[rd_idx[6:2]];
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_comb begin
    st_nxt = st_r;
    fuse_rd_en = 1'b0;
    // Load sequencer: one request, one capture, per word.
    case (st_r.seq)
      SEQ_REQ: begin
        fuse_rd_en = 1'b1;
        st_nxt.seq = SEQ_CAP;
      end
      SEQ_CAP: begin
        st_nxt.words[st_r.addr] = fuse_rd_data;
        if (st_r.addr == LAST_WORD) begin
          st_nxt.addr = 5'h0;
          st_nxt.seq = SEQ_DONE;
        end else begin
          st_nxt.addr = st_r.addr + 5'h1;
          st_nxt.seq = SEQ_REQ;
        end
      end
      SEQ_DONE: begin
        st_nxt.seq = SEQ_DONE;
      end
      default: begin
        st_nxt.seq = SEQ_REQ;
      end
    endcase

    // Outputs refresh every cycle once the image is complete.
    if (done) begin
      st_nxt.calib.hw_addr_valid = hw_ok;
      st_nxt.calib.hw_addr = hw_ok ? hw_field : '0;
      st_nxt.calib.bt_addr = hw_ok ? hw_field + 48'h1 : '0;
      st_nxt.calib.adc_valid = adc_ok;
      st_nxt.calib.adc_trim = adc_ok ? sel[P_ADC +: ADC_W] : '0;
      st_nxt.calib.xo_valid = xo_ok;
      st_nxt.calib.xo_trim = xo_ok ? sel[P_XO +: XO_W] : '0;
      st_nxt.calib.gain_valid = gain_ok;
      st_nxt.calib.gain_imbalance_trim = gain_ok ? sel[P_GAIN +: IQ_W] : '0;
      st_nxt.calib.phase_valid = phase_ok;
      st_nxt.calib.phase_imbalance_trim = phase_ok ? sel[P_PHASE +: IQ_W] : '0;
    end

    // Write channels are taken in either order; the response follows both.
    if (s_axi_awvalid && !st_r.aw_got && !st_r.bvalid) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.w_got && !st_r.bvalid) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    if (st_r.aw_got && st_r.w_got) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = RESP_OKAY;
      if (st_r.awaddr == OFS_CTRL) begin
        if (st_r.wstrb[0]) begin
          st_nxt.legacy = st_r.wdata[0];
          // A reload restarts the scan; calib holds its last values meanwhile while calib_ready is low.
          if (st_r.wdata[1]) begin
            st_nxt.seq = SEQ_REQ;
            st_nxt.addr = 5'h0;
          end
        end
      end else if (!((st_r.awaddr >= OFS_STATUS && st_r.awaddr <= OFS_SW && st_r.awaddr[1:0] == 2'b00) ||
                     (st_r.awaddr >= OFS_RAW_BASE && st_r.awaddr <= OFS_RAW_LAST &&
                      st_r.awaddr[1:0] == 2'b00))) begin
        st_nxt.bresp = RESP_SLVERR;
      end
    end else if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    if (s_axi_arvalid && !st_r.rvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rd_mux;
      st_nxt.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign fuse_rd_addr = st_r.addr;
  assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
  assign s_axi_wready = !st_r.w_got && !st_r.bvalid;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign calib = st_r.calib;
  assign calib_ready = done;

  // A reload that lands on the last capture legally restarts the scan instead of finishing it.
  logic reload_go;
  assign reload_go = st_r.aw_got && st_r.w_got && st_r.awaddr == OFS_CTRL && st_r.wstrb[0] && st_r.wdata[1];

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence last_capture_s;
    st_r.seq == SEQ_CAP && st_r.addr == LAST_WORD && !reload_go;
  endsequence

  sequence image_done_s;
    done ##1 done;
  endsequence

  load_complete_a: assert property (last_capture_s |=> done)
    else $error("Load did not finish after the last word.");

  read_range_a: assert property (fuse_rd_en |-> fuse_rd_addr <= LAST_WORD && !done)
    else $error("Fuse read outside the array.");

  pick_valid_a: assert property (found |-> bank_ok[active] &&
                                 (active == 3'h5 || !(|(bank_ok >> (active + 3'h1)))))
    else $error("Active bank is not the highest qualifying bank.");

  no_bank_a: assert property (!found |-> bank_ok == '0)
    else $error("Qualifying bank missed.");

  bt_address_a: assert property (image_done_s |->
                                 calib.bt_addr == calib.hw_addr + 48'h1 || !calib.hw_addr_valid)
    else $error("Second address is not hardware address plus one.");

  legacy_off_a: assert property (st_r.legacy && done |=> !calib.gain_valid && !calib.phase_valid)
    else $error("Imbalance trims applied in legacy mode.");

  gain_load_a: assert property (done && gain_ok |=>
                                calib.gain_valid && calib.gain_imbalance_trim == $past(sel[P_GAIN +: IQ_W]))
    else $error("Gain trim not loaded from active bank.");

  flag_zero_a: assert property (done && !sel[P_HW_VALID] |=> !calib.hw_addr_valid && calib.hw_addr == '0)
    else $error("Field used although its flag is clear.");

  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped before it was taken.");

endmodule : otp_fuse_bank_reader

//--- tb/fuse_array_model.sv
`timescale 1ns/1ps
module fuse_array_model (
  // Clock.
  input wire logic aclk,
  // Read port from the reader.
  input wire logic rd_en,
  input wire logic [4:0] rd_addr,
  output logic [31:0] rd_data,
  // Fuse contents set by the bench.
  input wire logic [767:0] image
);
  initial rd_data = 32'h0;
  // The word is held for one cycle only; afterwards the lines toggle so a late sample is caught.
  always @(posedge aclk) begin
    if (rd_en) begin
      rd_data <= image[rd_addr*32 +: 32];
    end else begin
      rd_data <= ~rd_data;
    end
  end
endmodule : fuse_array_model

//--- tb/otp_fuse_bank_reader_bench.sv
`timescale 1ns/1ps
module otp_fuse_bank_reader_bench;
  import otp_fuse_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  logic fuse_rd_en;
  logic [4:0] fuse_rd_addr;
  logic [31:0] fuse_rd_data;
  logic [767:0] image;
  calib_t calib;
  logic calib_ready;
  int failures, checks_done, cycles;

  otp_fuse_bank_reader dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fuse_rd_en(fuse_rd_en),
    .fuse_rd_addr(fuse_rd_addr), .fuse_rd_data(fuse_rd_data), .calib(calib), .calib_ready(calib_ready));
  fuse_array_model fuse (.aclk(aclk), .rd_en(fuse_rd_en), .rd_addr(fuse_rd_addr), .rd_data(fuse_rd_data),
    .image(image));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic summarize;
    if (failures == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize

  // A hung handshake is caught here rather than in every wait loop.
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      summarize();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // Ready is sampled on the falling edge; it cannot change before the next rising edge.
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_t, w_t, b_t;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(negedge aclk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid;
      r = bresp;
      @(posedge aclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (b_t) break;
    end
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_t, r_t;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(negedge aclk);
      ar_t = arvalid && arready;
      r_t = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar_t) arvalid <= 1'b0;
      if (r_t) break;
    end
    rready <= 1'b0;
  endtask : axi_read

  task automatic expect_reg(input logic [11:0] a, input logic [31:0] exp, input string what);
    axi_read(a, rd, rsp);
    check({30'h0, rsp}, {30'h0, RESP_OKAY}, what);
    check(rd, exp, what);
  endtask : expect_reg

  // Fuse programming by the factory or the customer, done in the bench's image.
  task automatic put_bank(input int b, input logic v, input logic rv, input logic [47:0] hw, input logic gv,
                          input logic [10:0] g);
    int o;
    o = b * 128;
    image[o +: 128] = '0;
    image[o + POS_BANK_VALID] = v;
    image[o + POS_BANK_REVOKED] = rv;
    if (v) begin
      image[o + POS_HW_VALID] = 1'b1;
      image[o + POS_HW_ADDR +: 48] = hw;
      if (b == 5) begin
        image[o + POS_ADC_VALID] = 1'b1;
        image[o + POS_ADC +: 8] = 8'h3c;
      end
      image[o + POS_XO_VALID] = 1'b1;
      image[o + POS_XO +: 15] = 15'h2bcd;
      image[o + POS_GAIN_VALID] = gv;
      image[o + POS_GAIN +: 11] = g;
      image[o + POS_PHASE_VALID] = gv;
      image[o + POS_PHASE +: 11] = ~g;
      image[o + 108 +: 20] = 20'h5a5a0 | 20'(b);
    end
  endtask : put_bank

  task automatic reload;
    int n;
    axi_write(OFS_CTRL, 32'h2, rsp);
    n = 0;
    while (calib_ready === 1'b1 && n < 10) begin
      @(posedge aclk);
      n++;
    end
    while (calib_ready !== 1'b1) @(posedge aclk);
    @(posedge aclk);
  endtask : reload

  task automatic t_factory;
    image = '0;
    put_bank(0, 1'b0, 1'b1, 48'h0, 1'b0, 11'h0);
    put_bank(1, 1'b0, 1'b1, 48'h0, 1'b0, 11'h0);
    put_bank(3, 1'b1, 1'b0, 48'h0012_3456_78ff, 1'b1, 11'h2a5);
    put_bank(4, 1'b1, 1'b1, 48'h0099_0000_0001, 1'b1, 11'h111);
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    while (calib_ready !== 1'b1) @(posedge aclk);
    @(posedge aclk);
    expect_reg(OFS_STATUS, 32'h133, "active bank");
    expect_reg(OFS_ADC, 32'h0, "unused converter trim");
    expect_reg(OFS_HW_LO, 32'h3456_78ff, "addr lo");
    expect_reg(OFS_HW_HI, 32'h0012, "addr hi");
    expect_reg(OFS_BT_LO, 32'h3456_7900, "second addr lo");
    expect_reg(OFS_BT_HI, 32'h0012, "second addr hi");
    check(calib.bt_addr[31:0], 32'h3456_7900, "second addr pin");
    expect_reg(OFS_FIELD_VALID, 32'h1d, "field flags");
    expect_reg(OFS_IQ, {5'h0, ~11'h2a5, 5'h0, 11'h2a5}, "imbalance trims");
    expect_reg(OFS_XO, 32'h2bcd, "crystal trim");
    expect_reg(OFS_SW, 32'h5a5a3, "software bits");
    expect_reg(OFS_RAW_BASE + 12'h030, image[12*32 +: 32], "raw word 12");
    expect_reg(OFS_RAW_LAST, image[23*32 +: 32], "raw word 23");
  endtask : t_factory

  task automatic t_legacy;
    axi_write(OFS_CTRL, 32'h1, rsp);
    repeat (2) @(posedge aclk);
    expect_reg(OFS_CTRL, 32'h1, "control");
    expect_reg(OFS_FIELD_VALID, 32'h5, "legacy flags");
    expect_reg(OFS_IQ, 32'h0, "legacy trims");
    check({31'h0, calib.gain_valid}, 32'h0, "legacy gain pin");
  endtask : t_legacy

  task automatic t_supersede;
    put_bank(3, 1'b1, 1'b1, 48'h0012_3456_78ff, 1'b1, 11'h2a5);
    put_bank(5, 1'b1, 1'b0, 48'h00ab_ffff_ffff, 1'b0, 11'h2a5);
    reload();
    expect_reg(OFS_STATUS, 32'h53, "new bank");
    expect_reg(OFS_BT_HI, 32'h00ac, "second addr carry");
    expect_reg(OFS_FIELD_VALID, 32'h7, "unused trims");
    expect_reg(OFS_ADC, 32'h3c, "converter trim");
    expect_reg(OFS_IQ, 32'h0, "ignored trims");
    expect_reg(OFS_SW, 32'h5a5a5, "software bits");
  endtask : t_supersede

  task automatic t_none;
    image = '0;
    put_bank(5, 1'b1, 1'b1, 48'h1, 1'b1, 11'h1);
    reload();
    expect_reg(OFS_STATUS, 32'h1, "no bank");
    expect_reg(OFS_FIELD_VALID, 32'h0, "no fields");
    check({31'h0, calib.hw_addr_valid}, 32'h0, "addr valid pin");
  endtask : t_none

  task automatic t_bad_access;
    axi_read(12'h02c, rd, rsp);
    check({30'h0, rsp}, {30'h0, RESP_SLVERR}, "unmapped read");
    check(rd, 32'h0, "unmapped data");
    axi_write(12'h200, 32'hffff_ffff, rsp);
    check({30'h0, rsp}, {30'h0, RESP_SLVERR}, "unmapped write");
    axi_write(OFS_STATUS, 32'h0, rsp);
    check({30'h0, rsp}, {30'h0, RESP_OKAY}, "read-only write");
    expect_reg(OFS_STATUS, 32'h1, "status kept");
  endtask : t_bad_access

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hf;
    image = '0;
    t_factory();
    t_legacy();
    t_supersede();
    t_none();
    t_bad_access();
    summarize();
  end
endmodule : otp_fuse_bank_reader_bench
